// [design/lcft_regs.vh]
// Register indices, field positions and reset values of the control frame trap.
// Assumes word indices; byte address is four times the index.
`ifndef LCFT_REGS_VH
`define LCFT_REGS_VH

// Word indices (byte address = index * 4)
`define LCFT_TBL_IDX 16'hDA1F
`define LCFT_TBL_WORDS 16'h0400
`define LCFT_LACP_IDX 16'hDE37
`define LCFT_LACP_WORDS 16'h0004
`define LCFT_PFX_IDX 16'hDE4D
`define LCFT_PFX_WORDS 16'h0002
`define LCFT_LLDP_IDX 16'hE00D
`define LCFT_LLDP_WORDS 16'h0008
`define LCFT_RCNT_IDX 16'hE100
`define LCFT_LCNT_IDX 16'hE101

// Decoded register selects
`define LCFT_SEL_NONE 3'h0
`define LCFT_SEL_TBL 3'h1
`define LCFT_SEL_PFX 3'h2
`define LCFT_SEL_LACP 3'h3
`define LCFT_SEL_LLDP 3'h4
`define LCFT_SEL_RCNT 3'h5
`define LCFT_SEL_LCNT 3'h6

// Field positions
`define LCFT_NPORT 24
`define LCFT_PFX_MSK_LSB 40
`define LCFT_LACP_DROP_LSB 49
`define LCFT_LACP_CPU_LSB 73
`define LCFT_LLDP_ETH_LSB 144
`define LCFT_LLDP_BPDU_BIT 160
`define LCFT_LLDP_MASK_LSB 161

// Reset values
`define LCFT_PFX_RST {16'hFFFF, 40'h180C20000}
`define LCFT_LACP_RST {48'h0, 48'h0180C2000002, 1'b1}
`define LCFT_LLDP_RST {24'h7FFFFF, 1'b0, 16'h88CC, 48'h0180C2000000, 48'h0180C2000003, 48'h0180C200000E}

// Bus answers
`define LCFT_RESP_OKAY 2'h0
`define LCFT_RESP_SLVERR 2'h2

`endif

// [design/lcft_trap.v]
// Control frame trap: reserved multicast, link aggregation control and
// link discovery classification with an AXI4-Lite register slave.
// Assumes frame descriptors come from logic on ref_clk, one per cycle.
//
// Contract
// R01 - Match upper 40 DA bits, index by low 8
// R02 - Mask bits select compared low prefix bits
// R03 - Prefix resets 01:80:c2:00:00, mask all ones
// R04 - Reserved drop per source port, counted
// R05 - Reserved CPU trap; discovery trap wins
// R06 - Redirect bit sends to five-bit target
// R07 - No action means normal forwarding
// R08 - Control frame is enabled exact address match
// R09 - Control frame drop per port, counted
// R10 - Control frame CPU trap per port
// R11 - Control drop beats control CPU trap
// R12 - Discovery needs one of three DAs, EtherType
// R13 - Three discovery addresses reset to defaults
// R14 - Discovery trap mask sends to CPU
// R15 - Suppression clears BPDU on discovery frames
// R16 - Reserved drop beats trap and redirect
//
// Chosen here: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "lcft_regs.vh"

module lcft_trap #(
    parameter CNT_W = 32
) (
    input wire ref_clk,
    input wire rst,
    input wire [17:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    output wire [1:0] s_axi_bresp,
    output wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire [17:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    output wire [31:0] s_axi_rdata,
    output wire [1:0] s_axi_rresp,
    output wire s_axi_rvalid,
    input wire s_axi_rready,
    input wire frmValid,
    input wire [47:0] frmDa,
    input wire [15:0] frmEtherType,
    input wire [4:0] frmSrcPort,
    input wire frmBpdu,
    output wire resValid,
    output wire resDrop,
    output wire resToCpu,
    output wire resRedirect,
    output wire [4:0] resPort,
    output wire resNormal,
    output wire resLacp,
    output wire resLldp,
    output wire resBpdu
);

// ----------------------------------------------------------------
// Helpers
// ----------------------------------------------------------------
// Byte-lane merge of a bus write into a stored word
function [31:0] mrg;
    input [31:0] old;
    input [31:0] nw;
    input [3:0] strb;
    integer b;
    begin
        mrg = old;
        for (b = 0; b < 4; b = b + 1) begin
            if (strb[b]) begin
                mrg[b*8 +: 8] = nw[b*8 +: 8];
            end
        end
    end
endfunction

// Word index to {select, entry, word}; shared by read and write
function [13:0] dec;
    input [15:0] idx;
    reg [15:0] off;
    begin
        off = 16'h0000;
        dec = {`LCFT_SEL_NONE, 11'h000};
        if (idx >= `LCFT_TBL_IDX &&
            idx < `LCFT_TBL_IDX + `LCFT_TBL_WORDS) begin
            off = idx - `LCFT_TBL_IDX;
            dec = {`LCFT_SEL_TBL, off[9:2], 1'b0, off[1:0]};
        end else if (idx >= `LCFT_LACP_IDX &&
            idx < `LCFT_LACP_IDX + `LCFT_LACP_WORDS) begin
            off = idx - `LCFT_LACP_IDX;
            dec = {`LCFT_SEL_LACP, 8'h00, off[2:0]};
        end else if (idx >= `LCFT_PFX_IDX &&
            idx < `LCFT_PFX_IDX + `LCFT_PFX_WORDS) begin
            off = idx - `LCFT_PFX_IDX;
            dec = {`LCFT_SEL_PFX, 8'h00, off[2:0]};
        end else if (idx >= `LCFT_LLDP_IDX &&
            idx < `LCFT_LLDP_IDX + `LCFT_LLDP_WORDS) begin
            off = idx - `LCFT_LLDP_IDX;
            dec = {`LCFT_SEL_LLDP, 8'h00, off[2:0]};
        end else if (idx == `LCFT_RCNT_IDX) begin
            dec = {`LCFT_SEL_RCNT, 11'h000};
        end else if (idx == `LCFT_LCNT_IDX) begin
            dec = {`LCFT_SEL_LCNT, 11'h000};
        end
    end
endfunction

// Per-port bit of a 24-bit mask; ports above 23 never hit
function portBit;
    input [23:0] msk;
    input [4:0] port;
    begin
        portBit = (port < `LCFT_NPORT) ? msk[port] : 1'b0;
    end
endfunction

// ----------------------------------------------------------------
// Storage
// ----------------------------------------------------------------
// Action table split into three word arrays, one per bus word
reg [31:0] tblLo [0:255];
reg [31:0] tblMid [0:255];
reg [12:0] tblHi [0:255];
// Wide registers padded to whole words; pad bits never read back
reg [63:0] pfx_r;
reg [127:0] lacp_r;
reg [255:0] lldp_r;
reg [CNT_W-1:0] rsvCnt_r;
reg [CNT_W-1:0] lacpCnt_r;

reg awready_r, wready_r, bvalid_r, arready_r, rvalid_r;
reg [1:0] bresp_r, rresp_r;
reg [31:0] rdata_r;
reg awHeld_r, wHeld_r;
reg [15:0] awIdx_r;
reg [31:0] wData_r;
reg [3:0] wStrb_r;

reg resValid_r, resDrop_r, resToCpu_r, resRedirect_r;
reg [4:0] resPort_r;
reg resNormal_r, resLacp_r, resLldp_r, resBpdu_r;

// ----------------------------------------------------------------
// Field views
// ----------------------------------------------------------------
wire [39:0] reservedPrefixValue = pfx_r[39:0];
wire [15:0] prefixMask = pfx_r[`LCFT_PFX_MSK_LSB +: 16];
wire lacpEnable = lacp_r[0];
wire [47:0] lacpAddr = lacp_r[48:1];
wire [23:0] lacpDropPorts = lacp_r[`LCFT_LACP_DROP_LSB +: 24];
wire [23:0] lacpCpuTrapPorts = lacp_r[`LCFT_LACP_CPU_LSB +: 24];
wire [47:0] lldpMatchAddrA = lldp_r[47:0];
wire [47:0] lldpMatchAddrB = lldp_r[95:48];
wire [47:0] lldpMatchAddrC = lldp_r[143:96];
wire [15:0] lldpEtherType = lldp_r[`LCFT_LLDP_ETH_LSB +: 16];
wire bpduSuppressSelect = lldp_r[`LCFT_LLDP_BPDU_BIT];
wire [23:0] lldpTrapPorts = lldp_r[`LCFT_LLDP_MASK_LSB +: 24];

// ----------------------------------------------------------------
// Classification
// ----------------------------------------------------------------
// Action entry picked by the low DA byte
wire [76:0] entry = {tblHi[frmDa[7:0]], tblMid[frmDa[7:0]],
    tblLo[frmDa[7:0]]};
wire [23:0] sourceDropBits = entry[23:0];
wire [23:0] sourceTrapBits = entry[47:24];
wire [23:0] redirectBits = entry[71:48];
wire [4:0] redirectTargetPort = entry[76:72];

wire rsvHit = (frmDa[47:24] == reservedPrefixValue[39:16]) &&
    (((frmDa[23:8] ^ reservedPrefixValue[15:0]) & prefixMask)
    == 16'h0000); // R01 R02
wire rsvDrop = rsvHit && portBit(sourceDropBits, frmSrcPort); // R04
wire rsvTrap = rsvHit && portBit(sourceTrapBits, frmSrcPort); // R05
wire rsvRedir = rsvHit && portBit(redirectBits, frmSrcPort); // R06
wire lacpHit = lacpEnable && (frmDa == lacpAddr); // R08
wire lacpDrop = lacpHit && portBit(lacpDropPorts, frmSrcPort); // R09
wire lacpTrap = lacpHit && portBit(lacpCpuTrapPorts, frmSrcPort); // R10
wire lldpHit = ((frmDa == lldpMatchAddrA) ||
    (frmDa == lldpMatchAddrB) || (frmDa == lldpMatchAddrC)) &&
    (frmEtherType == lldpEtherType); // R12
wire lldpTrap = lldpHit && portBit(lldpTrapPorts, frmSrcPort); // R14
// Any drop wins over every forwarding action
wire anyDrop = rsvDrop || lacpDrop; // R11 R16
// Discovery trap is checked first, the reserved trap only after it
wire anyCpu = !anyDrop && (lldpTrap || lacpTrap || rsvTrap); // R05 R10
wire anyRedir = !anyDrop && !anyCpu && rsvRedir; // R06 R16

// Result registers, one cycle behind the descriptor
always @(posedge ref_clk) begin
    if (rst) begin
        resValid_r <= 1'b0;
        resDrop_r <= 1'b0;
        resToCpu_r <= 1'b0;
        resRedirect_r <= 1'b0;
        resPort_r <= 5'h00;
        resNormal_r <= 1'b0;
        resLacp_r <= 1'b0;
        resLldp_r <= 1'b0;
        resBpdu_r <= 1'b0;
    end else begin
        resValid_r <= frmValid;
        resDrop_r <= frmValid && anyDrop;
        resToCpu_r <= frmValid && anyCpu;
        resRedirect_r <= frmValid && anyRedir;
        // Target shows only with a frame, never from idle fields
        resPort_r <= (frmValid && anyRedir) ? redirectTargetPort : 5'h00;
        resNormal_r <= frmValid && !anyDrop && !anyCpu && !anyRedir; // R07
        resLacp_r <= frmValid && lacpHit;
        resLldp_r <= frmValid && lldpHit;
        resBpdu_r <= frmValid && frmBpdu &&
            !(bpduSuppressSelect && lldpHit); // R15
    end
end

// ----------------------------------------------------------------
// AXI4-Lite slave
// ----------------------------------------------------------------
wire [13:0] wDec = dec(awIdx_r);
wire [13:0] rDec = dec(s_axi_araddr[17:2]);
wire doWrite = awHeld_r && wHeld_r && !bvalid_r;
// Top table word merged at full width, cut to its 13 bits on store
wire [31:0] hiMerged = mrg({19'h0, tblHi[wDec[10:3]]}, wData_r, wStrb_r);
wire rsvInc = frmValid && rsvDrop; // R04
wire lacpInc = frmValid && lacpDrop && !rsvDrop; // R09
integer k;

// Write path; address and data are taken in either order
always @(posedge ref_clk) begin
    if (rst) begin
        awready_r <= 1'b1;
        wready_r <= 1'b1;
        bvalid_r <= 1'b0;
        bresp_r <= `LCFT_RESP_OKAY;
        awHeld_r <= 1'b0;
        wHeld_r <= 1'b0;
        awIdx_r <= 16'h0000;
        wData_r <= 32'h00000000;
        wStrb_r <= 4'h0;
        pfx_r <= {8'h00, `LCFT_PFX_RST}; // R03
        lacp_r <= {31'h0, `LCFT_LACP_RST}; // R08
        lldp_r <= {71'h0, `LCFT_LLDP_RST}; // R12 R13
        rsvCnt_r <= {CNT_W{1'b0}};
        lacpCnt_r <= {CNT_W{1'b0}};
        for (k = 0; k < 256; k = k + 1) begin
            tblLo[k] <= 32'h00000000;
            tblMid[k] <= 32'h00000000;
            tblHi[k] <= 13'h0000;
        end
    end else begin
        if (awready_r && s_axi_awvalid) begin
            awIdx_r <= s_axi_awaddr[17:2];
            awHeld_r <= 1'b1;
            awready_r <= 1'b0;
        end
        if (wready_r && s_axi_wvalid) begin
            wData_r <= s_axi_wdata;
            wStrb_r <= s_axi_wstrb;
            wHeld_r <= 1'b1;
            wready_r <= 1'b0;
        end
        if (bvalid_r && s_axi_bready) begin
            bvalid_r <= 1'b0;
            awHeld_r <= 1'b0;
            wHeld_r <= 1'b0;
            awready_r <= 1'b1;
            wready_r <= 1'b1;
        end
        // Counter: a drop in the write cycle is added, not lost
        if (doWrite && wDec[13:11] == `LCFT_SEL_RCNT) begin
            rsvCnt_r <= mrg(rsvCnt_r, wData_r, wStrb_r) +
                {{(CNT_W-1){1'b0}}, rsvInc};
        end else if (rsvInc) begin
            rsvCnt_r <= rsvCnt_r + {{(CNT_W-1){1'b0}}, 1'b1}; // R04
        end
        if (doWrite && wDec[13:11] == `LCFT_SEL_LCNT) begin
            lacpCnt_r <= mrg(lacpCnt_r, wData_r, wStrb_r) +
                {{(CNT_W-1){1'b0}}, lacpInc};
        end else if (lacpInc) begin
            lacpCnt_r <= lacpCnt_r + {{(CNT_W-1){1'b0}}, 1'b1}; // R09
        end
        if (doWrite) begin
            bvalid_r <= 1'b1;
            bresp_r <= (wDec[13:11] == `LCFT_SEL_NONE) ?
                `LCFT_RESP_SLVERR : `LCFT_RESP_OKAY;
            if (wDec[13:11] == `LCFT_SEL_TBL) begin
                if (wDec[1:0] == 2'h0) begin
                    tblLo[wDec[10:3]] <=
                        mrg(tblLo[wDec[10:3]], wData_r, wStrb_r);
                end else if (wDec[1:0] == 2'h1) begin
                    tblMid[wDec[10:3]] <=
                        mrg(tblMid[wDec[10:3]], wData_r, wStrb_r);
                end else if (wDec[1:0] == 2'h2) begin
                    tblHi[wDec[10:3]] <= hiMerged[12:0];
                end
            end
            for (k = 0; k < 8; k = k + 1) begin
                if (wDec[2:0] == k) begin
                    if (wDec[13:11] == `LCFT_SEL_LLDP) begin
                        lldp_r[k*32 +: 32] <=
                            mrg(lldp_r[k*32 +: 32], wData_r, wStrb_r);
                    end
                    if (wDec[13:11] == `LCFT_SEL_LACP && k < 4) begin
                        lacp_r[k*32 +: 32] <=
                            mrg(lacp_r[k*32 +: 32], wData_r, wStrb_r);
                    end
                    if (wDec[13:11] == `LCFT_SEL_PFX && k < 2) begin
                        pfx_r[k*32 +: 32] <=
                            mrg(pfx_r[k*32 +: 32], wData_r, wStrb_r);
                    end
                end
            end
        end
    end
end

// Read views with unused high bits forced to zero
wire [255:0] lldpRd = {71'h0, lldp_r[184:0]};
wire [127:0] lacpRd = {31'h0, lacp_r[96:0]};
wire [63:0] pfxRd = {8'h00, pfx_r[55:0]};
reg [31:0] rdMux;

// Read data selection
always @* begin
    rdMux = 32'h00000000;
    if (rDec[13:11] == `LCFT_SEL_TBL) begin
        if (rDec[1:0] == 2'h0) begin
            rdMux = tblLo[rDec[10:3]];
        end else if (rDec[1:0] == 2'h1) begin
            rdMux = tblMid[rDec[10:3]];
        end else if (rDec[1:0] == 2'h2) begin
            rdMux = {19'h0, tblHi[rDec[10:3]]};
        end
    end else if (rDec[13:11] == `LCFT_SEL_LLDP) begin
        rdMux = lldpRd[rDec[2:0]*32 +: 32];
    end else if (rDec[13:11] == `LCFT_SEL_LACP) begin
        rdMux = lacpRd[rDec[1:0]*32 +: 32];
    end else if (rDec[13:11] == `LCFT_SEL_PFX) begin
        rdMux = pfxRd[rDec[0]*32 +: 32];
    end else if (rDec[13:11] == `LCFT_SEL_RCNT) begin
        rdMux = rsvCnt_r;
    end else if (rDec[13:11] == `LCFT_SEL_LCNT) begin
        rdMux = lacpCnt_r;
    end
end

// Read path; answer one cycle after the address is taken
always @(posedge ref_clk) begin
    if (rst) begin
        arready_r <= 1'b1;
        rvalid_r <= 1'b0;
        rdata_r <= 32'h00000000;
        rresp_r <= `LCFT_RESP_OKAY;
    end else if (arready_r && s_axi_arvalid) begin
        arready_r <= 1'b0;
        rvalid_r <= 1'b1;
        rdata_r <= rdMux;
        rresp_r <= (rDec[13:11] == `LCFT_SEL_NONE) ?
            `LCFT_RESP_SLVERR : `LCFT_RESP_OKAY;
    end else if (rvalid_r && s_axi_rready) begin
        rvalid_r <= 1'b0;
        arready_r <= 1'b1;
    end
end

// ----------------------------------------------------------------
// Outputs
// ----------------------------------------------------------------
assign s_axi_awready = awready_r;
assign s_axi_wready = wready_r;
assign s_axi_bvalid = bvalid_r;
assign s_axi_bresp = bresp_r;
assign s_axi_arready = arready_r;
assign s_axi_rvalid = rvalid_r;
assign s_axi_rdata = rdata_r;
assign s_axi_rresp = rresp_r;
assign resValid = resValid_r;
assign resDrop = resDrop_r;
assign resToCpu = resToCpu_r;
assign resRedirect = resRedirect_r;
assign resPort = resPort_r;
assign resNormal = resNormal_r;
assign resLacp = resLacp_r;
assign resLldp = resLldp_r;
assign resBpdu = resBpdu_r;

endmodule // lcft_trap

// [sim/lcft_trap_sva.sv]
// Checker for the trap block's bus handshakes and result pulses.
// Assumes it is bound to lcft_trap and sees only its ports.
`timescale 1ns/1ps
module lcft_trap_sva (
    input wire ref_clk,
    input wire rst,
    input wire s_axi_awready,
    input wire s_axi_wready,
    input wire [1:0] s_axi_bresp,
    input wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire s_axi_rvalid,
    input wire s_axi_rready,
    input wire frmValid,
    input wire frmBpdu,
    input wire resValid,
    input wire resDrop,
    input wire resToCpu,
    input wire resRedirect,
    input wire [4:0] resPort,
    input wire resNormal,
    input wire resLacp,
    input wire resLldp,
    input wire resBpdu
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    // ------------------------------------------------------------
    // Result path
    // ------------------------------------------------------------
    chk_one_class: assert property (
        resValid |-> $onehot({resDrop, resToCpu, resRedirect, resNormal}))
        else $error("result class not one-hot");
    chk_res_latency: assert property (resValid == $past(frmValid))
        else $error("result not one cycle after descriptor");
    chk_port_idle: assert property (
        resValid && !resRedirect |-> resPort == 5'h00)
        else $error("target port set without redirect");
    chk_bpdu_pass: assert property (
        resValid && !resLldp |-> resBpdu == $past(frmBpdu))
        else $error("bpdu changed on non-discovery frame");
    chk_res_quiet: assert property (!resValid |->
        !(resDrop || resToCpu || resRedirect || resNormal || resLacp ||
        resLldp || resBpdu || resPort != 5'h00))
        else $error("class bit without result");
    // ------------------------------------------------------------
    // Register bus
    // ------------------------------------------------------------
    chk_b_stand: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write answer dropped early");
    chk_r_stand: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read answer dropped early");
    chk_r_answer: assert property (s_axi_arvalid && s_axi_arready |=>
        s_axi_rvalid && !s_axi_arready)
        else $error("read not answered next cycle");
    chk_b_busy: assert property (s_axi_bvalid |->
        !s_axi_awready && !s_axi_wready)
        else $error("write channel ready during answer");
endmodule // lcft_trap_sva

bind lcft_trap lcft_trap_sva lcft_trap_sva_i (.ref_clk(ref_clk), .rst(rst),
    .s_axi_awready(s_axi_awready), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .frmValid(frmValid), .frmBpdu(frmBpdu), .resValid(resValid),
    .resDrop(resDrop), .resToCpu(resToCpu), .resRedirect(resRedirect),
    .resPort(resPort), .resNormal(resNormal), .resLacp(resLacp),
    .resLldp(resLldp), .resBpdu(resBpdu));

// [sim/lcft_ingress_model.sv]
// Ingress pipeline model: offers one frame descriptor at a time.
// Assumes the caller samples the result at the edge after return.
`timescale 1ns/1ps
module lcft_ingress_model (
    input wire ref_clk,
    output reg frmValid = 1'b0,
    output reg [47:0] frmDa = 48'h000000000000,
    output reg [15:0] frmEtherType = 16'h0000,
    output reg [4:0] frmSrcPort = 5'h00,
    output reg frmBpdu = 1'b0
);
    // ------------------------------------------------------------
    // Descriptor driver
    // ------------------------------------------------------------
    // Fields are inverted once released so stale values never match
    task send(input [47:0] da, input [15:0] et, input [4:0] p, input b);
        begin
            @(posedge ref_clk);
            frmValid <= 1'b1;
            frmDa <= da;
            frmEtherType <= et;
            frmSrcPort <= p;
            frmBpdu <= b;
            @(posedge ref_clk);
            frmValid <= 1'b0;
            frmDa <= ~da;
            frmEtherType <= ~et;
            frmSrcPort <= ~p;
            frmBpdu <= ~b;
        end
    endtask
endmodule // lcft_ingress_model

// [sim/testbench.sv]
// Self-checking bench for the trap block over AXI4-Lite and frames.
// Assumes the register header and a 100 ns ref_clk.
`timescale 1ns/1ps
`include "lcft_regs.vh"
module testbench;
    reg ref_clk = 1'b0;
    reg rst = 1'b1;
    reg [17:0] awAddr = 18'h00000, arAddr = 18'h00000;
    reg [31:0] wData = 32'h00000000, rdv;
    reg [3:0] wStrb = 4'h0;
    reg awValid = 1'b0, wValid = 1'b0, bReady = 1'b0;
    reg arValid = 1'b0, rReady = 1'b0;
    reg [1:0] rsp;
    wire awReady, wReady, bValid, arReady, rValid, frmValid, frmBpdu;
    wire resValid, resDrop, resToCpu, resRedirect, resNormal;
    wire resLacp, resLldp, resBpdu;
    wire [1:0] bResp, rResp;
    wire [31:0] rData;
    wire [47:0] frmDa;
    wire [15:0] frmEtherType;
    wire [4:0] frmSrcPort, resPort;
    integer miscompares = 0, samplesChecked = 0, cycles = 0, k;
    localparam [11:0] DROP = 12'h800, CPU = 12'h400, RDR = 12'h200;
    localparam [11:0] NORM = 12'h008, LACP = 12'h004, LLDP = 12'h002;
    localparam [11:0] BPDU = 12'h001;
    localparam [47:0] LDA = 48'h0180C200000E, RDA = 48'h0180C2000010;
    localparam [47:0] CDA = 48'h0180C2000002;
    reg [47:0] rstTab [0:10] = '{48'hDE4D80C20000, 48'hDE4E00FFFF01,
        48'hDE3784000005, 48'hDE3800000301, 48'hE00DC200000E,
        48'hE00E00030180, 48'hE00F0180C200, 48'hE010C2000000,
        48'hE01188CC0180, 48'hE01200FFFFFE, 48'hDA5F00000000};

    initial forever #50 ref_clk = ~ref_clk;

    lcft_trap lcft_trap_i (.ref_clk(ref_clk), .rst(rst),
        .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid),
        .s_axi_awready(awReady), .s_axi_wdata(wData), .s_axi_wstrb(wStrb),
        .s_axi_wvalid(wValid), .s_axi_wready(wReady), .s_axi_bresp(bResp),
        .s_axi_bvalid(bValid), .s_axi_bready(bReady),
        .s_axi_araddr(arAddr), .s_axi_arvalid(arValid),
        .s_axi_arready(arReady), .s_axi_rdata(rData), .s_axi_rresp(rResp),
        .s_axi_rvalid(rValid), .s_axi_rready(rReady), .frmValid(frmValid),
        .frmDa(frmDa), .frmEtherType(frmEtherType),
        .frmSrcPort(frmSrcPort), .frmBpdu(frmBpdu), .resValid(resValid),
        .resDrop(resDrop), .resToCpu(resToCpu), .resRedirect(resRedirect),
        .resPort(resPort), .resNormal(resNormal), .resLacp(resLacp),
        .resLldp(resLldp), .resBpdu(resBpdu));

    lcft_ingress_model lcft_ingress_model_i (.ref_clk(ref_clk),
        .frmValid(frmValid), .frmDa(frmDa), .frmEtherType(frmEtherType),
        .frmSrcPort(frmSrcPort), .frmBpdu(frmBpdu));

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task check(input string what, input [31:0] seen, input [31:0] exp);
        begin
            samplesChecked = samplesChecked + 1;
            if (seen !== exp) begin
                miscompares = miscompares + 1;
                $display("wrong value %0s exp %h seen %h", what, exp, seen);
            end
        end
    endtask

    task endSim;
        begin
            $display("checks %0d mismatches %0d", samplesChecked, miscompares);
            if (miscompares == 0 && samplesChecked > 0)
                $display("== PASSED ==");
            else
                $display("== FAILED ==");
            $finish;
        end
    endtask

    // Address and data offered together, each dropped once taken;
    // bready comes late so the answer must stand for a cycle
    task wr(input [15:0] idx, input [31:0] d);
        begin
            @(posedge ref_clk);
            awAddr <= {idx, 2'b00};
            wData <= d;
            wStrb <= 4'hF;
            awValid <= 1'b1;
            wValid <= 1'b1;
            do begin
                @(posedge ref_clk);
                if (awReady) awValid <= 1'b0;
                if (wReady) wValid <= 1'b0;
                if (bValid === 1'b1 && !bReady) bReady <= 1'b1;
            end while (!(bValid === 1'b1 && bReady));
            bReady <= 1'b0;
            rsp = bResp;
        end
    endtask

    task rd(input [15:0] idx);
        begin
            @(posedge ref_clk);
            arAddr <= {idx, 2'b00};
            arValid <= 1'b1;
            do begin
                @(posedge ref_clk);
                if (arReady) arValid <= 1'b0;
                if (rValid === 1'b1 && !rReady) rReady <= 1'b1;
            end while (!(rValid === 1'b1 && rReady));
            rReady <= 1'b0;
            rdv = rData;
            rsp = rResp;
        end
    endtask

    task rc(input [15:0] idx, input [31:0] exp);
        begin
            rd(idx);
            check("rdata", rdv, exp);
            check("rresp", rsp, `LCFT_RESP_OKAY);
        end
    endtask

    // Result is sampled at the edge that closes its one-cycle pulse
    task fr(input [47:0] da, input [15:0] et, input [4:0] p, input b,
            input [11:0] exp);
        begin
            lcft_ingress_model_i.send(da, et, p, b);
            @(posedge ref_clk);
            check("result", {resDrop, resToCpu, resRedirect, resPort,
                resNormal, resLacp, resLldp, resBpdu}, exp);
        end
    endtask

    // Hang guard, far above the two hundred or so cycles needed
    always @(posedge ref_clk) begin
        cycles = cycles + 1;
        if (cycles == 20000) begin
            miscompares = miscompares + 1;
            endSim;
        end
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (8) @(posedge ref_clk);
        rst <= 1'b0;
        for (k = 0; k < 11; k = k + 1)
            rc(rstTab[k][47:32], rstTab[k][31:0]);
        rd(16'h0100);
        check("rdata", rdv, 32'h00000000);
        check("rresp", rsp, `LCFT_RESP_SLVERR);
        wr(16'h0100, 32'hFFFFFFFF);
        check("bresp", rsp, `LCFT_RESP_SLVERR);
        $display("test reset done");
        fr(LDA, 16'h88CC, 5'h05, 1'b1, CPU | LLDP | BPDU);
        fr(LDA, 16'h88CC, 5'h17, 1'b0, NORM | LLDP);
        fr(LDA, 16'h88CD, 5'h05, 1'b0, NORM);
        fr(48'h0180C2000003, 16'h88CC, 5'h00, 1'b0, CPU | LLDP);
        fr(48'h0180C2000000, 16'h88CC, 5'h00, 1'b0, CPU | LLDP);
        fr(CDA, 16'h8809, 5'h03, 1'b0, NORM | LACP);
        $display("test defaults done");
        wr(16'hDA5F, 32'h14000012);
        wr(16'hDA60, 32'h00940000);
        wr(16'hDA61, 32'h00001500);
        wr(16'hDA62, 32'hFFFFFFFF);
        rc(16'hDA61, 32'h00001500);
        rc(16'hDA62, 32'h00000000);
        fr(RDA, 16'h0800, 5'h01, 1'b0, DROP);
        fr(RDA, 16'h0800, 5'h02, 1'b0, CPU);
        fr(RDA, 16'h0800, 5'h04, 1'b0, DROP);
        fr(RDA, 16'h0800, 5'h07, 1'b0, RDR | 12'h150);
        fr(RDA, 16'h0800, 5'h08, 1'b0, NORM);
        fr(48'h0180C3000010, 16'h0800, 5'h01, 1'b0, NORM);
        fr(48'h0180C2005A10, 16'h0800, 5'h01, 1'b0, NORM);
        wr(16'hDE4E, 32'h00FF0001);
        fr(48'h0180C2005A10, 16'h0800, 5'h01, 1'b0, DROP);
        fr(48'h0180C2015A10, 16'h0800, 5'h01, 1'b0, NORM);
        rc(`LCFT_RCNT_IDX, 32'h00000003);
        $display("test reserved done");
        wr(16'hDE38, 32'h04100301);
        wr(16'hDE39, 32'h00048000);
        fr(CDA, 16'h8809, 5'h03, 1'b0, DROP | LACP);
        fr(CDA, 16'h8809, 5'h06, 1'b0, CPU | LACP);
        fr(CDA, 16'h8809, 5'h09, 1'b0, DROP | LACP);
        rc(`LCFT_LCNT_IDX, 32'h00000002);
        wr(16'hDE37, 32'h84000004);
        fr(CDA, 16'h8809, 5'h03, 1'b0, NORM);
        $display("test lacp done");
        wr(16'hE012, 32'h00FFFFFF);
        fr(LDA, 16'h88CC, 5'h05, 1'b1, CPU | LLDP);
        fr(48'h0180C2000001, 16'h8808, 5'h05, 1'b1, NORM | BPDU);
        $display("test suppress done");
        endSim;
    end
endmodule // testbench
